/* File: core/scw_pkg.sv */
// Package for the status and control word block.
// Assumes one clock domain and a cyclic fieldbus exchange.
package scw_pkg;

  // Identification status field positions
  localparam int SID_NONE      = 0;
  localparam int SID_SINGLE    = 2;
  localparam int SID_SHARED    = 3;
  localparam int SID_INVALID   = 4;
  localparam int SID_ACTIVE    = 5;
  localparam int SID_CFG_FAIL  = 6;
  localparam int SID_RD_ERR    = 7;
  localparam int SID_CRC_ERR   = 8;
  localparam int SID_BLANK     = 9;

  // I/O flag status field positions
  localparam int IO_DIN_RAW    = 0;
  localparam int IO_DIN_DEB    = 2;
  localparam int IO_DOUT       = 4;
  localparam int IO_DOUT_DLY   = 6;
  localparam int IO_LIMIT      = 8;
  localparam int IO_CALC       = 12;
  localparam int IO_ZERO_BIT   = 30;
  localparam int IO_ONE_BIT    = 31;
  localparam int IO_FBUS       = 32;
  localparam int IO_ETH        = 48;

  // Flag selector index meaning no flag
  localparam logic [6:0] SEL_NONE = 7'h40;

  // Blank module bytes
  localparam int          BLANK_BYTES = 256;
  localparam logic [7:0]  BYTE_LOW    = 8'h00;
  localparam logic [7:0]  BYTE_HIGH   = 8'hFF;

  // Command bit positions
  localparam int CMD_ZERO      = 0;
  localparam int CMD_TARE      = 1;
  localparam int CMD_CLR_ZERO  = 2;
  localparam int CMD_CLR_TARE  = 3;
  localparam int CMD_SCALE1    = 4;
  localparam int CMD_SCALE2    = 5;
  localparam int CMD_HOLD_CAP  = 6;
  localparam int CMD_DEL_CAP   = 8;
  localparam int CMD_RST_LIM   = 10;
  localparam int CMD_RST_PEAK  = 14;
  localparam int CMD_HOLD_PEAK = 15;
  localparam int CMD_FILT_FAST = 16;
  localparam int CMD_SAVE      = 17;
  localparam logic [31:0] CMD_DEFINED = 32'h0003FFFF;

  localparam logic [31:0] RST_WORD32 = 32'h00000000;
  localparam logic [63:0] RST_WORD64 = 64'h0000000000000000;

  // Identification result from the sensor module reader
  typedef struct packed {
    logic none;
    logic single;
    logic shared;
    logic invalid;
    logic active;
    logic cfg_fail;
    logic rd_err;
    logic crc_err;
  } scw_sid_t;

  // Raw flag sources feeding the I/O word
  typedef struct packed {
    logic [1:0]  din_raw;
    logic [1:0]  din_deb;
    logic [1:0]  dout;
    logic [1:0]  dout_dly;
    logic [3:0]  limit;
    logic [7:0]  calc;
    logic [15:0] fbus;
    logic [15:0] eth;
  } scw_io_t;

  // One-cycle action strobes for the command bits
  typedef struct packed {
    logic       zero;
    logic       tare;
    logic       clr_zero;
    logic       clr_tare;
    logic [1:0] scale;
    logic [1:0] hold_cap;
    logic [1:0] del_cap;
    logic [3:0] rst_lim;
    logic       rst_peak;
    logic       filt_fast;
    logic       save;
  } scw_act_t;

endpackage

/* File: core/scw_blank_check.sv */
// Blank detector over the first bytes of an identification module.
// Assumes bytes arrive in order after a start pulse.
`timescale 1ns/1ns
`default_nettype none
module scw_blank_check (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  output logic            done,
  output logic            blank
);

  logic [8:0] count;
  logic       all_low;
  logic       all_high;

  ////////////////////////////////////////////////////////////////////////////
  // RULE_06: blank byte scan
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count    <= 9'h000;
      all_low  <= 1'b1;
      all_high <= 1'b1;
      done     <= 1'b0;
      blank    <= 1'b0;
    end else if (start) begin
      count    <= 9'h000;
      all_low  <= 1'b1;
      all_high <= 1'b1;
      done     <= 1'b0;
      blank    <= 1'b0;
    end else if (byte_valid && !done) begin
      count    <= count + 9'h001;
      all_low  <= all_low && (byte_data == scw_pkg::BYTE_LOW);
      all_high <= all_high && (byte_data == scw_pkg::BYTE_HIGH);
      if (count == 9'(scw_pkg::BLANK_BYTES - 1)) begin
        done  <= 1'b1;
        blank <= (all_low && (byte_data == scw_pkg::BYTE_LOW)) ||
                 (all_high && (byte_data == scw_pkg::BYTE_HIGH));
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/scw_status_ctrl.sv */
// Cyclic status words and command word with echo acknowledge.
// Assumes the fieldbus side samples words once per update strobe.
//
// Contract
// RULE_01: 32-bit identification status, bit 0 means no module found.
// RULE_02: Bit 2 single-wire module detected, bit 3 shared-line module.
// RULE_03: Bit 4 invalid contents, bit 5 all templates read and applied.
// RULE_04: Bit 6 settings not applied, bit 7 module unreadable.
// RULE_05: Bit 8 checksum fails; module is only read, never written.
// RULE_06: Bit 9 blank module, first 256 bytes all 0 or all 255.
// RULE_07: 64-bit I/O word; bits 0-1 raw inputs, 2-3 debounced.
// RULE_08: Bits 4-5 outputs direct, bits 6-7 delayed outputs.
// RULE_09: Bits 8-11 limit switch results 1 to 4.
// RULE_10: Bits 12-19 calc flags, 20-29 unused, 30 zero, 31 one.
// RULE_11: Bits 32-47 fieldbus flags, 48-63 Ethernet flags.
// RULE_12: Flag selector index 64 selects no flag.
// RULE_13: Any command change runs every set bit again.
// RULE_14: Controller keeps undefined command bits at zero.
// RULE_15: Executed word echoed; controller clears bit after matching echo.
// RULE_16: Bits 0-3 zero, tare, clear zero, clear tare.
// RULE_17: Bits 4-5 capture two-point scaling points one and two.
// RULE_18: Bits 6-7 hold captured values, 8-9 delete them.
// RULE_19: Bits 10-13 reset limit switches 1 to 4.
// RULE_20: Bit 14 resets peak values; bit 15 freezes while set.
// RULE_21: Bit 16 filter fast-track; bit 17 save parameter set.
// RULE_22: Status words update atomically at one instant.
`timescale 1ns/1ns
`default_nettype none
module scw_status_ctrl (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             update,
  input  wire scw_pkg::scw_sid_t sid_in,
  input  wire logic             id_start,
  input  wire logic             id_byte_valid,
  input  wire logic [7:0]       id_byte,
  input  wire scw_pkg::scw_io_t io_in,
  input  wire logic [6:0]       flag_sel,
  input  wire logic [31:0]      command_word,
  input  wire logic             busy,
  output logic [31:0]           sensor_id_status,
  output logic [63:0]           io_flag_status,
  output logic                  sel_flag,
  output logic [31:0]           cmd_echo,
  output scw_pkg::scw_act_t     act,
  output logic                  hold_peak,
  output logic                  id_write_en
);

  typedef enum logic [1:0] {
    SCW_IDLE,
    SCW_EXEC,
    SCW_ACK
  } scw_state_t;

  scw_state_t  state;
  logic [31:0] cmd_prev;
  logic [31:0] cmd_live;
  logic [63:0] next_io;
  logic [31:0] next_sid;
  logic        blank_done;
  logic        blank;

  function automatic logic cbit(input logic [31:0] w, input int pos);
    return w[pos];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Blank module detector
  scw_blank_check u_blank (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .start     (id_start),
    .byte_valid(id_byte_valid),
    .byte_data (id_byte),
    .done      (blank_done),
    .blank     (blank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // RULE_05: read-only module access
  assign id_write_en = 1'b0;

  // RULE_01: identification word build
  always_comb begin
    next_sid = scw_pkg::RST_WORD32;
    next_sid[scw_pkg::SID_NONE]     = sid_in.none;
    // RULE_02: module type bits
    next_sid[scw_pkg::SID_SINGLE]   = sid_in.single;
    next_sid[scw_pkg::SID_SHARED]   = sid_in.shared;
    // RULE_03: contents and active bits
    next_sid[scw_pkg::SID_INVALID]  = sid_in.invalid;
    next_sid[scw_pkg::SID_ACTIVE]   = sid_in.active;
    // RULE_04: config and read errors
    next_sid[scw_pkg::SID_CFG_FAIL] = sid_in.cfg_fail;
    next_sid[scw_pkg::SID_RD_ERR]   = sid_in.rd_err;
    // RULE_05: checksum error bit
    next_sid[scw_pkg::SID_CRC_ERR]  = sid_in.crc_err;
    // RULE_06: blank module bit
    next_sid[scw_pkg::SID_BLANK]    = blank_done && blank;
  end

  // RULE_07: I/O word build
  always_comb begin
    next_io = scw_pkg::RST_WORD64;
    next_io[scw_pkg::IO_DIN_RAW +: 2]  = io_in.din_raw;
    next_io[scw_pkg::IO_DIN_DEB +: 2]  = io_in.din_deb;
    // RULE_08: output bits
    next_io[scw_pkg::IO_DOUT +: 2]     = io_in.dout;
    next_io[scw_pkg::IO_DOUT_DLY +: 2] = io_in.dout_dly;
    // RULE_09: limit switch bits
    next_io[scw_pkg::IO_LIMIT +: 4]    = io_in.limit;
    // RULE_10: calc flags and constants
    next_io[scw_pkg::IO_CALC +: 8]     = io_in.calc;
    next_io[scw_pkg::IO_ZERO_BIT]      = 1'b0;
    next_io[scw_pkg::IO_ONE_BIT]       = 1'b1;
    // RULE_11: bus flag halves
    next_io[scw_pkg::IO_FBUS +: 16]    = io_in.fbus;
    next_io[scw_pkg::IO_ETH +: 16]     = io_in.eth;
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_22: snapshot both words together
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sensor_id_status <= scw_pkg::RST_WORD32;
      io_flag_status   <= scw_pkg::RST_WORD64 |
                          (64'h1 << scw_pkg::IO_ONE_BIT);
    end else if (update) begin
      sensor_id_status <= next_sid;
      io_flag_status   <= next_io;
    end
  end

  // RULE_12: selector 64 gives no flag
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sel_flag <= 1'b0;
    end else if (flag_sel >= scw_pkg::SEL_NONE) begin
      sel_flag <= 1'b0;
    end else begin
      sel_flag <= io_flag_status[flag_sel[5:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE_14: undefined bits masked for hold_peak; change detect and echo use all bits
  assign cmd_live = command_word & scw_pkg::CMD_DEFINED;

  // RULE_13: change detect and re-run
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state    <= SCW_IDLE;
      cmd_prev <= scw_pkg::RST_WORD32;
    end else begin
      case (state)
        SCW_IDLE: begin
          if (command_word != cmd_prev) begin
            cmd_prev <= command_word;
            state    <= SCW_EXEC;
          end
        end
        SCW_EXEC: begin
          state <= SCW_ACK;
        end
        SCW_ACK: begin
          if (!busy) begin
            state <= SCW_IDLE;
          end
        end
        default: begin
          state <= SCW_IDLE;
        end
      endcase
    end
  end

  // RULE_15: echo after execution
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_echo <= scw_pkg::RST_WORD32;
    end else if (state == SCW_ACK && !busy) begin
      cmd_echo <= cmd_prev;
    end
  end

  // Action strobes, one cycle, in the cycle after the exec state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      act <= '0;
    end else if (state == SCW_EXEC) begin
      // RULE_16: zero and tare actions
      act.zero      <= cbit(cmd_prev, scw_pkg::CMD_ZERO);
      act.tare      <= cbit(cmd_prev, scw_pkg::CMD_TARE);
      act.clr_zero  <= cbit(cmd_prev, scw_pkg::CMD_CLR_ZERO);
      act.clr_tare  <= cbit(cmd_prev, scw_pkg::CMD_CLR_TARE);
      // RULE_17: scaling point capture
      act.scale     <= cmd_prev[scw_pkg::CMD_SCALE1 +: 2];
      // RULE_18: capture hold and delete
      act.hold_cap  <= cmd_prev[scw_pkg::CMD_HOLD_CAP +: 2];
      act.del_cap   <= cmd_prev[scw_pkg::CMD_DEL_CAP +: 2];
      // RULE_19: limit switch reset
      act.rst_lim   <= cmd_prev[scw_pkg::CMD_RST_LIM +: 4];
      // RULE_20: peak reset
      act.rst_peak  <= cbit(cmd_prev, scw_pkg::CMD_RST_PEAK);
      // RULE_21: filter fast-track and save
      act.filt_fast <= cbit(cmd_prev, scw_pkg::CMD_FILT_FAST);
      act.save      <= cbit(cmd_prev, scw_pkg::CMD_SAVE);
    end else begin
      act <= '0;
    end
  end

  // RULE_20: peak freeze level
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hold_peak <= 1'b0;
    end else begin
      hold_peak <= cbit(cmd_live, scw_pkg::CMD_HOLD_PEAK);
    end
  end

endmodule
`default_nettype wire

/* File: sim/scw_status_ctrl_properties.sv */
// Checker for the status and control word block.
// Assumes it is bound to scw_status_ctrl.
`timescale 1ns/1ns
`default_nettype none
module scw_props (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              update,
  input wire scw_pkg::scw_sid_t sid_in,
  input wire scw_pkg::scw_io_t  io_in,
  input wire logic [6:0]        flag_sel,
  input wire logic [31:0]       command_word,
  input wire logic              busy,
  input wire logic [31:0]       sensor_id_status,
  input wire logic [63:0]       io_flag_status,
  input wire logic              sel_flag,
  input wire logic [31:0]       cmd_echo,
  input wire scw_pkg::scw_act_t act,
  input wire logic              hold_peak,
  input wire logic              id_write_en
);
  logic [31:0] cw_d1;
  logic [31:0] cw_d2;
  logic [16:0] exp_act;
  always_ff @(posedge core_clk) begin
    cw_d1 <= command_word;
    cw_d2 <= cw_d1;
  end
  assign exp_act = {cw_d2[0], cw_d2[1], cw_d2[2], cw_d2[3], cw_d2[5:4],
    cw_d2[7:6], cw_d2[9:8], cw_d2[13:10], cw_d2[14], cw_d2[16], cw_d2[17]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  io_fixed_a: assert property (
    io_flag_status[31:20] == 12'h800) else $error("fixed io bits wrong");
  io_low_a: assert property (
    update |=> io_flag_status[19:0] == $past({io_in.calc, io_in.limit,
    io_in.dout_dly, io_in.dout, io_in.din_deb, io_in.din_raw}))
    else $error("io low word wrong");
  io_high_a: assert property (
    update |=> io_flag_status[63:32] == $past({io_in.eth, io_in.fbus}))
    else $error("io high word wrong");
  sid_map_a: assert property (
    update |=> sensor_id_status[8:0] == $past({sid_in[0], sid_in[1],
    sid_in[2], sid_in[3], sid_in[4], sid_in[5], sid_in[6], 1'b0, sid_in[7]}))
    else $error("id status map wrong");
  word_hold_a: assert property (
    !update |=> $stable(io_flag_status) && $stable(sensor_id_status))
    else $error("status moved without update");
  act_map_a: assert property (
    act != '0 |-> act == exp_act) else $error("action strobes wrong");
  act_pulse_a: assert property (
    act != '0 |=> act == '0) else $error("action longer than one cycle");
  echo_busy_a: assert property (
    $changed(cmd_echo) |-> !$past(busy)) else $error("echo moved while busy");
  echo_val_a: assert property (
    act != '0 && !busy |-> ##[1:2] cmd_echo == cw_d2)
    else $error("echo not the executed word");
  hold_peak_a: assert property (
    hold_peak == $past(command_word[15])) else $error("peak hold wrong");
  sel_none_a: assert property (
    flag_sel[6] && $past(flag_sel[6]) |-> !sel_flag)
    else $error("index 64 selected a flag");
  no_write_a: assert property (
    id_write_en == 1'b0) else $error("module write enabled");
endmodule
bind scw_status_ctrl scw_props chk_u (.core_clk(core_clk), .nrst(nrst),
  .update(update), .sid_in(sid_in), .io_in(io_in), .flag_sel(flag_sel),
  .command_word(command_word), .busy(busy), .cmd_echo(cmd_echo),
  .sensor_id_status(sensor_id_status), .io_flag_status(io_flag_status),
  .sel_flag(sel_flag), .act(act), .hold_peak(hold_peak),
  .id_write_en(id_write_en));
`default_nettype wire

/* File: sim/scw_ctrl_model.sv */
// Controller model that drives the command word.
// Assumes the block echoes each executed word.
`timescale 1ns/1ns
`default_nettype none
module scw_ctrl_model (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] req_word,
  input  wire logic [31:0] cmd_echo,
  output var  logic [31:0] command_word
);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      command_word <= 32'h00000000;
    end else if (cmd_echo == command_word) begin
      command_word <= req_word & scw_pkg::CMD_DEFINED;
    end
  end
endmodule
`default_nettype wire

/* File: sim/scw_status_ctrl_tb_top.sv */
// Testbench for the status and control word block.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module scw_status_ctrl_tb_top;
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              update = 1'b0;
  logic              id_start = 1'b0;
  logic              id_byte_valid = 1'b0;
  logic              busy = 1'b0;
  logic [7:0]        id_byte = 8'h00;
  logic [6:0]        flag_sel = 7'h00;
  logic [31:0]       req_word = 32'h00000000;
  scw_pkg::scw_sid_t sid_in = '0;
  scw_pkg::scw_io_t  io_in = '0;
  logic [31:0]       command_word, sid_st, cmd_echo;
  logic [63:0]       io_st, e;
  logic              sel_flag, hold_peak;
  scw_pkg::scw_act_t act;
  logic [16:0]       seen;
  int                n_fail = 0;
  int                num_checks = 0;
  always #2 core_clk = ~core_clk;
  scw_ctrl_model ctl_u (.core_clk(core_clk), .nrst(nrst),
    .req_word(req_word), .cmd_echo(cmd_echo), .command_word(command_word));
  scw_status_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .update(update),
    .sid_in(sid_in), .id_start(id_start), .id_byte_valid(id_byte_valid),
    .id_byte(id_byte), .io_in(io_in), .flag_sel(flag_sel),
    .command_word(command_word), .busy(busy), .sensor_id_status(sid_st),
    .io_flag_status(io_st), .sel_flag(sel_flag), .cmd_echo(cmd_echo),
    .act(act), .hold_peak(hold_peak), .id_write_en());
  function automatic logic [63:0] exp_io(input scw_pkg::scw_io_t v);
    return {v.eth, v.fbus, 12'h800, v.calc, v.limit, v.dout_dly, v.dout,
      v.din_deb, v.din_raw};
  endfunction
  function automatic logic [63:0] exp_sid(input scw_pkg::scw_sid_t s,
                                          input logic b);
    return {54'h0, b, s.crc_err, s.rd_err, s.cfg_fail, s.active, s.invalid,
      s.shared, s.single, 1'b0, s.none};
  endfunction
  function automatic logic [63:0] exp_act(input logic [31:0] c);
    return {47'h0, c[0], c[1], c[2], c[3], c[5:4], c[7:6], c[9:8],
      c[13:10], c[14], c[16], c[17]};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic load(input scw_pkg::scw_sid_t s, input scw_pkg::scw_io_t v);
    @(posedge core_clk);
    sid_in <= s;
    io_in <= v;
    update <= 1'b1;
    @(posedge core_clk);
    update <= 1'b0;
    tick(1);
  endtask
  task automatic scan(input logic [7:0] b, input logic [7:0] odd);
    @(posedge core_clk);
    id_start <= 1'b1;
    @(posedge core_clk);
    id_start <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      id_byte_valid <= 1'b1;
      id_byte <= (i == 100) ? odd : b;
      @(posedge core_clk);
    end
    id_byte_valid <= 1'b0;
    load(sid_in, io_in);
  endtask
  task automatic run_cmd(input logic [31:0] w);
    int k;
    seen = 17'h0;
    @(posedge core_clk);
    req_word <= w;
    for (k = 0; k < 40 && !(cmd_echo === w && command_word === w); k++) begin
      tick(1);
      seen = seen | act;
    end
    if (k == 40) begin
      chk(64'h1, 64'h0);
      test_done();
    end
    tick(2);
  endtask
  initial begin
    logic [31:0] w;
    tick(5);
    nrst <= 1'b1;
    tick(1);
    chk(io_st, 64'h0000000080000000);
    chk({sid_st, cmd_echo}, 64'h0);
    for (int i = 0; i < 2; i++) begin
      load(i ? 8'hA5 : 8'h5A, i ? 52'h5A5A5A5A5A5A5 : 52'hA5A5A5A5A5A5A);
      e = exp_io(io_in);
      chk(io_st, e);
      chk(64'(sid_st), exp_sid(sid_in, 1'b0));
      flag_sel <= i ? 7'h25 : 7'h0C;
      tick(3);
      chk(64'(sel_flag), 64'(e[flag_sel[5:0]]));
      flag_sel <= 7'h40;
      io_in <= ~io_in;
      tick(3);
      chk(64'(sel_flag), 64'h0);
      chk(io_st, e);
    end
    scan(8'hFF, 8'hFF);
    chk(64'(sid_st), exp_sid(sid_in, 1'b1));
    scan(8'h00, 8'h00);
    chk(64'(sid_st), exp_sid(sid_in, 1'b1));
    scan(8'hFF, 8'h12);
    chk(64'(sid_st), exp_sid(sid_in, 1'b0));
    for (int i = 0; i < 18; i++) begin
      w = (32'h2 << i) - 32'h1;
      run_cmd(w);
      chk(64'(seen), exp_act(w));
      chk(64'(cmd_echo), 64'(w));
      chk(64'(hold_peak), 64'(w[15]));
    end
    run_cmd(32'h0);
    chk(64'(seen), 64'h0);
    busy <= 1'b1;
    req_word <= 32'h3;
    tick(12);
    chk(64'(cmd_echo), 64'h0);
    busy <= 1'b0;
    run_cmd(32'h3);
    chk(64'(cmd_echo), 64'h3);
    test_done();
  end
endmodule
`default_nettype wire
